// >>> pkg/mtf_map.svh
`ifndef MTF_MAP_SVH
`define MTF_MAP_SVH

// Register offsets (byte addresses)
`define MTF_CFG_BASE      12'h000
`define MTF_STAT_BASE     12'h100

// Channel configuration word fields
`define MTF_CFG_MODE_LSB  0
`define MTF_CFG_IFS_BIT   3
`define MTF_CFG_FSEL_BIT  4
`define MTF_CFG_PAUSE_BIT 5
`define MTF_CFG_GAP_LSB   8
`define MTF_CFG_FLAG_LSB  16
`define MTF_CFG_RESET     32'h0000_0100

// Line characters
`define MTF_HDLC_FLAG     8'h7E
`define MTF_MARK_IDLE     8'hFF
`define MTF_ZERO_CHAR     8'h00

// Fixed 10-octet framing counts
`define MTF_V110_LAST_POS 4'h9
`define MTF_V110_ZBASE    6'h14
`define MTF_V110_ZABORT   6'h1E

// Bus responses
`define MTF_RESP_OKAY     2'h0
`define MTF_RESP_SLVERR   2'h2

`endif

// >>> pkg/mtf_pkg.sv
package mtf_pkg;

   typedef enum logic [2:0] {
      mtf_hdlc,
      mtf_octet_transparent_mode_b,
      mtf_octet_transparent_mode_r,
      mtf_slot_transparent_mode,
      mtf_v110
   } mtf_mode_t;

   typedef enum logic [1:0] {
      mtf_st_idle,
      mtf_st_frame,
      mtf_st_close,
      mtf_st_zfill
   } mtf_state_t;

   typedef struct packed {
      mtf_state_t st;
      logic [7:0] cnt;
      logic [3:0] pos;
      logic [5:0] zcnt;
      logic       started;
      logic       discard;
      logic       dhold;
      logic [7:0] esx;
      logic [7:0] esx_pend;
      logic       pend_v;
   } mtf_chan_t;

endpackage

// >>> verif/mtf_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module mtf_peer_model (
   // Clock
   input wire logic       aclk,
   // Serial highway
   input wire logic       tx_valid,
   input wire logic [7:0] tx_octet,
   input wire logic       tx_abort,
   // Observed line
   output var int         octets,
   output logic [7:0]     last_octet,
   output var int         aborts
);
   initial begin
      octets = 0;
      aborts = 0;
      last_octet = 8'h00;
   end
   // Peer takes one octet per slot
   always @(posedge aclk) begin
      if (tx_valid) begin
         octets <= octets + 1;
         last_octet <= tx_octet;
      end
      if (tx_abort) aborts <= aborts + 1;
   end
endmodule
`default_nettype wire

// >>> verif/mtf_tx_hold_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mtf_tx_hold_chk #(
   parameter int CHANNELS = 32
) (
   // Clock and reset
   input wire logic                        aclk,
   input wire logic                        aresetn,
   // Bus answers
   input wire logic                        s_axi_bvalid,
   input wire logic                        s_axi_bready,
   input wire logic [1:0]                  s_axi_bresp,
   input wire logic                        s_axi_rvalid,
   input wire logic                        s_axi_rready,
   input wire logic [31:0]                 s_axi_rdata,
   // Slot path
   input wire logic                        slot_valid,
   input wire logic [$clog2(CHANNELS)-1:0] slot_chan,
   input wire logic [$clog2(CHANNELS)-1:0] tb_chan,
   input wire logic [$clog2(CHANNELS)-1:0] tx_chan,
   input wire logic                        tx_valid,
   input wire logic                        tx_abort,
   input wire logic                        tb_pop,
   input wire logic                        poll,
   input wire logic                        branch,
   input wire logic [31:0]                 branch_ptr,
   input wire logic                        desc_pause,
   input wire logic [31:0]                 desc_next_ptr
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_slot_octet_lat: assert property (tx_valid == $past(slot_valid, 2))
      else $error("octet not two cycles after slot");
   a_chan_load: assert property ($past(slot_valid) |-> tb_chan == $past(slot_chan))
      else $error("buffer channel not slot channel");
   a_chan_store: assert property (tx_valid |-> tx_chan == $past(slot_chan, 2))
      else $error("octet channel wrong");
   a_poll_in_slot: assert property (poll |-> tx_valid)
      else $error("poll outside a slot");
   a_branch_clear: assert property (branch |-> poll && !$past(desc_pause)
      && branch_ptr == $past(desc_next_ptr))
      else $error("branch without clear poll");
   a_abort_slot: assert property (tx_abort |-> tx_valid && !branch)
      else $error("abort outside a slot");
   a_pop_slot: assert property (tb_pop |-> tx_valid)
      else $error("pop outside a slot");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
endmodule

bind mtf_tx_hold mtf_tx_hold_chk #(.CHANNELS(CHANNELS)) u_chk (
   .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .slot_valid, .slot_chan, .tb_chan, .tx_chan,
   .tx_valid, .tx_abort, .tb_pop, .poll, .branch, .branch_ptr, .desc_pause,
   .desc_next_ptr);
`default_nettype wire

// >>> verif/test_mtf_tx_hold.sv
`timescale 1ns/1ps
`default_nettype none
module test_mtf_tx_hold;
   logic aclk = 0, aresetn = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
   logic s_axi_arvalid = 0, s_axi_rready = 1;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic slot_valid = 0;
   logic [4:0] slot_chan = 0, tb_chan, tx_chan;
   logic tb_avail = 0, tb_last = 0, tb_enough = 0, desc_pause = 1;
   logic [7:0] tb_data = 0, tx_octet;
   logic [31:0] desc_next_ptr = 0, branch_ptr, cfgs [7], d;
   logic [31:0] tb_fetch_stop;
   logic tb_pop, poll, branch, tx_valid, tx_abort;
   logic [7:0] fills [7], o, lo, ex = 0;
   logic [1:0] r;
   logic p, b, a, pp, ec = 0;
   int miscompares = 0, check_count = 0, cyc = 0, sent = 0, n, oc, ab;

   mtf_tx_hold dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .slot_valid, .slot_chan, .tb_chan, .tb_avail, .tb_data, .tb_last,
      .tb_access_end(1'b1), .tb_esx_chg(ec), .tb_esx(ex), .tb_enough,
      .tb_pop, .tb_fetch_stop, .desc_pause, .desc_next_ptr, .poll, .branch,
      .branch_ptr, .tx_valid, .tx_octet, .tx_chan, .tx_abort);
   mtf_peer_model peer (.aclk, .tx_valid, .tx_octet, .tx_abort, .octets(oc),
      .last_octet(lo), .aborts(ab));

   always #4 aclk = ~aclk;

   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task wr(input logic [11:0] ad, input logic [31:0] dt);
      s_axi_awaddr <= ad; s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp; break;
         end
      end
   endtask

   task rd(input logic [11:0] ad);
      s_axi_araddr <= ad; s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata; r = s_axi_rresp; break;
         end
      end
   endtask

   // One slot: strobe, buffer inputs held, answer two edges later
   task slot(input logic [4:0] c);
      slot_valid <= 1'b1; slot_chan <= c;
      @(posedge aclk) slot_valid <= 1'b0;
      @(posedge aclk);
      @(posedge aclk);
      sent++;
      chk("tx_valid", tx_valid, 1'b1);
      o = tx_octet; p = poll; b = branch; a = tx_abort; pp = tb_pop;
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test;
      end
   end

   initial begin
      cfgs = '{32'h100, 32'h108, 32'h101, 32'h102, 32'h103, 32'h5A0113, 32'h104};
      fills = '{8'h7E, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h5A, 8'h00};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(12'h000); chk("cfg reset", d, 32'h100);
      rd(12'h800); chk("unmapped resp", r, 2'h2); chk("unmapped data", d, 0);
      wr(12'h100, 32'h0); chk("status write", r, 2'h2);
      for (int i = 0; i < 7; i++) begin
         wr(12'h000, cfgs[i]); chk("cfg resp", r, 2'h0);
         slot(0); chk("fill char", o, fills[i]);
      end
      wr(12'h004, 32'h300); n = 0;
      for (int i = 0; i < 4; i++) begin
         desc_next_ptr <= 32'h100 + i;
         slot(1); n += p;
      end
      chk("poll count", n, 2);
      desc_pause <= 0; tb_avail <= 1; tb_enough <= 1; tb_data <= 8'hA5;
      desc_next_ptr <= 32'h240;
      slot(1); chk("open flag", o, 8'h7E);
      chk("branch", b, 1'b1); chk("branch ptr", branch_ptr, 32'h240);
      slot(1); chk("data", o, 8'hA5); chk("pop", pp, 1'b1);
      tb_data <= 8'h3C; tb_last <= 1;
      slot(1); chk("last data", o, 8'h3C);
      tb_avail <= 0; tb_last <= 0;
      slot(1); chk("close flag", o, 8'h7E);
      tb_avail <= 1; tb_data <= 8'h11; n = 0;
      while (!b && n < 8) begin
         slot(1); n++;
      end
      chk("restart", b, 1'b1);
      slot(1); chk("data", o, 8'h11);
      desc_pause <= 1;
      slot(1); chk("abort", a, 1'b1); chk("abort fill", o, 8'h7E);
      chk("fetch stop", tb_fetch_stop[1], 1'b1);
      wr(12'h004, 32'h320); desc_pause <= 0; n = 0;
      for (int i = 0; i < 3; i++) begin
         slot(1); n += p + b; chk("paused fill", o, 8'h7E);
      end
      chk("paused polls", n, 0);
      wr(12'h008, 32'h104); ec <= 1; ex <= 8'hC3;
      slot(2); chk("esx header", o, 8'hC3); chk("esx pop", pp, 1);
      ec <= 0; tb_last <= 1;
      slot(2); chk("section end", o, 8'h11);
      tb_last <= 0; n = 0;
      while (o != 8'hC3 && n < 30) begin
         slot(2); n++;
      end
      chk("zero run", n, 23);
      wr(12'h008, 32'h124);
      slot(2); chk("v110 abort", a, 1);
      slot(2); chk("discard pop", pp, 1);
      @(posedge aclk);
      chk("peer octets", oc, sent);
      chk("peer aborts", ab, 2);
      finish_test;
   end
endmodule
`default_nettype wire

// >>> verilog/mtf_axil_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "mtf_map.svh"

module mtf_axil_regs #(
   parameter int CHANNELS = 32,
   parameter int ADDR_W   = 12
) (
   // Clock and reset
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // Write channels
   input  wire logic [ADDR_W-1:0]            awaddr,
   input  wire logic                         awvalid,
   output logic                              awready,
   input  wire logic [31:0]                  wdata,
   input  wire logic [3:0]                   wstrb,
   input  wire logic                         wvalid,
   output logic                              wready,
   output logic [1:0]                        bresp,
   output logic                              bvalid,
   input  wire logic                         bready,
   // Read channels
   input  wire logic [ADDR_W-1:0]            araddr,
   input  wire logic                         arvalid,
   output logic                              arready,
   output logic [31:0]                       rdata,
   output logic [1:0]                        rresp,
   output logic                              rvalid,
   input  wire logic                         rready,
   // Block side
   output logic [CHANNELS-1:0][31:0]         cfg_q,
   input  wire logic [CHANNELS-1:0][7:0]     stat
);
   import mtf_pkg::*;

   localparam int CW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

   logic [ADDR_W-1:0] aw_a_q;
   logic              aw_v_q;
   logic [31:0]       w_d_q;
   logic [3:0]        w_s_q;
   logic              w_v_q;
   logic              aw_take;
   logic              w_take;
   logic              do_wr;
   logic              ar_take;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
      hit = (a >= base) && ((a - base) < ADDR_W'(4 * CHANNELS));
   endfunction

   function automatic logic [CW-1:0] idx(input logic [ADDR_W-1:0] a,
                                         input logic [ADDR_W-1:0] base);
      logic [ADDR_W-1:0] off;
      off = (a - base) >> 2;
      idx = off[CW-1:0];
   endfunction

   assign aw_take = awvalid && awready;
   assign w_take  = wvalid && wready;
   assign do_wr   = aw_v_q && w_v_q && !bvalid;
   assign ar_take = arvalid && arready;

   // Address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_v_q  <= 1'b0;
         awready <= 1'b1;
         aw_a_q  <= '0;
      end else if (aw_take) begin
         aw_v_q  <= 1'b1;
         awready <= 1'b0;
         aw_a_q  <= awaddr;
      end else if (do_wr) begin
         aw_v_q  <= 1'b0;
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_v_q  <= 1'b0;
         wready <= 1'b1;
         w_d_q  <= '0;
         w_s_q  <= '0;
      end else if (w_take) begin
         w_v_q  <= 1'b1;
         wready <= 1'b0;
         w_d_q  <= wdata;
         w_s_q  <= wstrb;
      end else if (do_wr) begin
         w_v_q  <= 1'b0;
         wready <= 1'b1;
      end
   end

   // Configuration words with byte enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < CHANNELS; i++) begin
            cfg_q[i] <= `MTF_CFG_RESET;
         end
      end else if (do_wr && hit(aw_a_q, `MTF_CFG_BASE)) begin
         for (int b = 0; b < 4; b++) begin
            if (w_s_q[b]) begin
               cfg_q[idx(aw_a_q, `MTF_CFG_BASE)][8*b +: 8] <= w_d_q[8*b +: 8];
            end
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `MTF_RESP_OKAY;
      end else if (do_wr) begin
         bvalid <= 1'b1;
         bresp  <= hit(aw_a_q, `MTF_CFG_BASE) ? `MTF_RESP_OKAY : `MTF_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= `MTF_RESP_OKAY;
      end else if (ar_take) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= `MTF_RESP_OKAY;
         if (hit(araddr, `MTF_CFG_BASE)) begin
            rdata <= cfg_q[idx(araddr, `MTF_CFG_BASE)];
         end else if (hit(araddr, `MTF_STAT_BASE)) begin
            rdata <= {24'h000000, stat[idx(araddr, `MTF_STAT_BASE)]};
         end else begin
            rdata <= '0;
            rresp <= `MTF_RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// >>> verilog/mtf_tx_hold.sv
// Behaviour
// RL1: Host zeroes minimum fill count in flag modes
// RL2: Delimiter 7E for HDLC, 00 otherwise; slot mode here sends its fill character
// RL3: Idle fill 7E/FF by select, 00 transparent
// RL4: After gap minus one idles, poll pause
// RL5: Branch to pointer from poll finding clear
// RL6: Host zeroes fill count in V.110 mode
// RL7: Host supplies E/S/X in first descriptor
// RL8: Sections run across frames, skip status items
// RL9: New E/S/X only at frame boundary
// RL10: Frame end or pause aborts V.110 line
// RL11: V.110 frame end sends 20+y zeros
// RL12: Slot mode fill FF or programmed flag
// RL13: Descriptor pause aborts frame, flags, idles
// RL14: Channel pause stops descriptor polling
// RL15: Channel pause finishes frame; V.110 aborts
// RL16: Descriptor pause stops fetches until enough
// RL17: Channel pause ignores gap count
// RL18: Channel pause acts on current frame
// RL19: Channel pause between frames blocks start
// RL20: V.110 pause aborts, sends 20+y zeros
// RL21: Discard rest of aborted memory access
// RL22: V.110 pause before first frame: none
// RL23: Per-channel state loaded and written back
`timescale 1ns/1ps
`default_nettype none
`include "mtf_map.svh"

module mtf_tx_hold #(
   parameter int CHANNELS = 32,
   parameter int ADDR_W   = 12
) (
   // Clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0]             s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   // Time slot strobe
   input  wire logic                          slot_valid,
   input  wire logic [$clog2(CHANNELS)-1:0]   slot_chan,
   // Transmit buffer head for tb_chan
   output logic [$clog2(CHANNELS)-1:0]        tb_chan,
   input  wire logic                          tb_avail,
   input  wire logic [7:0]                    tb_data,
   input  wire logic                          tb_last,
   input  wire logic                          tb_access_end,
   input  wire logic                          tb_esx_chg,
   input  wire logic [7:0]                    tb_esx,
   input  wire logic                          tb_enough,
   output logic                               tb_pop,
   output logic [CHANNELS-1:0]                tb_fetch_stop,
   // Descriptor poll for tb_chan
   input  wire logic                          desc_pause,
   input  wire logic [31:0]                   desc_next_ptr,
   output logic                               poll,
   output logic                               branch,
   output logic [31:0]                        branch_ptr,
   // Serial highway side
   output logic                               tx_valid,
   output logic [7:0]                         tx_octet,
   output logic [$clog2(CHANNELS)-1:0]        tx_chan,
   output logic                               tx_abort
);
   import mtf_pkg::*;

   localparam int CW = $clog2(CHANNELS);

   logic [CHANNELS-1:0][31:0] cfg;
   logic [CHANNELS-1:0][7:0]  stat_q;
   mtf_chan_t                 mem_q [CHANNELS];
   mtf_chan_t                 cur_q;
   mtf_chan_t                 nxt;
   logic                      act_q;
   logic [CW-1:0]             chan_q;
   logic [31:0]               cw;
   mtf_mode_t                 md;
   logic                      pause;
   logic [7:0]                gap;
   logic [7:0]                fill;
   logic [7:0]                oct;
   logic                      pop;
   logic                      poll_d;
   logic                      brn;
   logic                      abrt;
   logic                      hdr;

   mtf_axil_regs #(
      .CHANNELS (CHANNELS),
      .ADDR_W   (ADDR_W)
   ) u_regs (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .cfg_q   (cfg),
      .stat    (stat_q)
   );

   // Idle fill character per mode
   function automatic logic [7:0] fill_char(input mtf_mode_t m, input logic [31:0] c);
      case (m)
         mtf_hdlc:                  fill_char = c[`MTF_CFG_IFS_BIT] ? `MTF_MARK_IDLE
                                                                     : `MTF_HDLC_FLAG; // [RL3]
         mtf_slot_transparent_mode: fill_char = c[`MTF_CFG_FSEL_BIT] ? c[`MTF_CFG_FLAG_LSB +: 8]
                                                                      : `MTF_MARK_IDLE; // [RL12]
         default:                   fill_char = `MTF_ZERO_CHAR; // [RL3]
      endcase
   endfunction

   // Opening and closing delimiter per mode
   function automatic logic [7:0] delim_char(input mtf_mode_t m, input logic [31:0] c);
      case (m)
         mtf_hdlc:                  delim_char = `MTF_HDLC_FLAG; // [RL2]
         mtf_slot_transparent_mode: delim_char = fill_char(m, c);
         default:                   delim_char = `MTF_ZERO_CHAR; // [RL2]
      endcase
   endfunction

   // Slot load with forwarding of a back-to-back write-back
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_q  <= 1'b0;
         chan_q <= '0;
         cur_q  <= '0;
      end else begin
         act_q  <= slot_valid;
         chan_q <= slot_chan;
         if (act_q && chan_q == slot_chan) begin
            cur_q <= nxt;
         end else begin
            cur_q <= mem_q[slot_chan]; // [RL23]
         end
      end
   end

   assign cw    = cfg[chan_q];
   assign md    = mtf_mode_t'(cw[`MTF_CFG_MODE_LSB +: 3]);
   assign pause = cw[`MTF_CFG_PAUSE_BIT];
   assign gap   = cw[`MTF_CFG_GAP_LSB +: 8];
   assign fill  = fill_char(md, cw);

   // Per-slot formatter decision
   always_comb begin
      nxt    = cur_q;
      oct    = fill;
      pop    = 1'b0;
      poll_d = 1'b0;
      brn    = 1'b0;
      abrt   = 1'b0;
      hdr    = 1'b0;
      if (md != mtf_v110) begin
         case (cur_q.st)
            mtf_st_idle: begin
               if (pause) begin
                  nxt.cnt = 8'h00; // [RL14] [RL17] [RL19]
               end else if ({1'b0, cur_q.cnt} + 9'h001 < {1'b0, gap}) begin
                  nxt.cnt = 8'(cur_q.cnt + 8'h01);
               end else begin
                  poll_d = 1'b1; // [RL4]
                  if (desc_pause) begin
                     nxt.dhold = 1'b1; // [RL13]
                  end else begin
                     nxt.dhold = 1'b0;
                     if (tb_avail && tb_enough) begin
                        brn    = 1'b1; // [RL5]
                        oct    = delim_char(md, cw);
                        nxt.st = mtf_st_frame; // [RL16]
                     end
                  end
               end
            end
            mtf_st_frame: begin
               if (tb_hold_abort(tb_avail, desc_pause)) begin
                  abrt      = 1'b1; // [RL13]
                  nxt.st    = mtf_st_idle;
                  nxt.cnt   = 8'h00;
                  nxt.dhold = 1'b1;
               end else if (tb_avail) begin
                  oct = tb_data; // [RL15] [RL18]
                  pop = 1'b1;
                  if (tb_last) begin
                     nxt.st = mtf_st_close;
                  end
               end
            end
            mtf_st_close: begin
               oct     = delim_char(md, cw); // [RL2]
               nxt.st  = mtf_st_idle;
               nxt.cnt = 8'h00;
            end
            default: begin
               nxt.st = mtf_st_idle;
            end
         endcase
      end else begin
         oct = `MTF_ZERO_CHAR;
         case (cur_q.st)
            mtf_st_idle: begin
               if (!pause && tb_avail && tb_enough) begin
                  hdr = 1'b1; // [RL22]
               end
            end
            mtf_st_frame: begin
               if (pause || desc_pause || (cur_q.pos == 4'h0 && tb_last)) begin
                  abrt          = 1'b1; // [RL10] [RL15]
                  nxt.st        = mtf_st_zfill;
                  nxt.zcnt      = 6'(`MTF_V110_ZABORT - {2'b00, cur_q.pos}); // [RL20]
                  nxt.discard   = pause; // [RL21]
                  nxt.started   = 1'b0;
               end else if (cur_q.pos == 4'h0) begin
                  hdr = 1'b1;
               end else if (tb_avail && tb_esx_chg) begin
                  pop          = 1'b1; // [RL8]
                  nxt.esx_pend = tb_esx; // [RL9]
                  nxt.pend_v   = 1'b1;
               end else begin
                  if (tb_avail) begin
                     oct = tb_data; // [RL8]
                     pop = 1'b1;
                  end
                  if (tb_avail && tb_last) begin
                     nxt.st   = mtf_st_zfill; // [RL11]
                     nxt.zcnt = 6'(`MTF_V110_ZBASE + {2'b00, cur_q.pos} + 6'h01);
                  end else if (cur_q.pos == `MTF_V110_LAST_POS) begin
                     nxt.pos = 4'h0;
                  end else begin
                     nxt.pos = 4'(cur_q.pos + 4'h1);
                  end
               end
            end
            mtf_st_zfill: begin
               if (cur_q.discard && tb_avail) begin
                  pop = 1'b1; // [RL21]
                  if (tb_access_end) begin
                     nxt.discard = 1'b0;
                  end
               end
               if (cur_q.zcnt <= 6'h01) begin
                  nxt.st   = mtf_st_idle;
                  nxt.zcnt = 6'h00;
               end else begin
                  nxt.zcnt = 6'(cur_q.zcnt - 6'h01); // [RL11] [RL20]
               end
            end
            default: begin
               nxt.st = mtf_st_idle;
            end
         endcase
         if (hdr) begin
            nxt.st      = mtf_st_frame;
            nxt.pos     = 4'h1;
            nxt.started = 1'b1;
            if (cur_q.pend_v) begin
               nxt.esx    = cur_q.esx_pend; // [RL9]
               nxt.pend_v = 1'b0;
            end else if (tb_avail && tb_esx_chg) begin
               nxt.esx = tb_esx; // [RL9]
               pop     = 1'b1;
            end
            oct = nxt.esx;
         end
      end
   end

   // Descriptor pause seen mid-frame unless the frame's last octet is available in the same slot
   function automatic logic tb_hold_abort(input logic avail, input logic dp);
      tb_hold_abort = dp && !(avail && tb_last);
   endfunction

   // Per-channel state write-back
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < CHANNELS; i++) begin
            mem_q[i] <= '0;
         end
      end else if (act_q) begin
         mem_q[chan_q] <= nxt; // [RL23]
      end
   end

   // Status snapshot and fetch control per channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q        <= '0;
         tb_fetch_stop <= '0;
      end else if (act_q) begin
         stat_q[chan_q]        <= {nxt.st, nxt.started, nxt.dhold, nxt.discard, nxt.pend_v,
                                   2'b00};
         tb_fetch_stop[chan_q] <= nxt.dhold; // [RL16]
      end
   end

   // Registered slot outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tb_chan    <= '0;
         tx_valid   <= 1'b0;
         tx_octet   <= '0;
         tx_chan    <= '0;
         tx_abort   <= 1'b0;
         tb_pop     <= 1'b0;
         poll       <= 1'b0;
         branch     <= 1'b0;
         branch_ptr <= '0;
      end else begin
         tb_chan  <= slot_chan;
         tx_valid <= act_q;
         tx_octet <= oct;
         tx_chan  <= chan_q;
         tx_abort <= act_q && abrt; // [RL13]
         tb_pop   <= act_q && pop;
         poll     <= act_q && poll_d; // [RL4]
         branch   <= act_q && brn;
         if (act_q && poll_d) begin
            branch_ptr <= desc_next_ptr; // [RL4] [RL5]
         end
      end
   end

endmodule
`default_nettype wire
